// ==== mma_modulator_mode_arbiter.v ====
`timescale 1ns/1ps
`include "mma_defs.vh"

module mma_modulator_mode_arbiter #(
    parameter integer GAP_CYC = `MMA_GAP_CYC,
    parameter integer WIN_CYC = `MMA_WIN_CYC
) (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [11:0] strap_mv,
    input  wire [31:0] strap_resistor,
    input  wire        mcu_modulation_input,
    input  wire        internal_mod_data,
    output reg         modulation_switch_a,
    output reg         modulation_switch_b,
    output reg         bypass_active,
    output reg         standalone_cfg,
    output reg  [15:0] target_mv
);
    // ------------------------------------------------------------
    // Constants and state codes
    // ------------------------------------------------------------
    localparam [1:0]  ST_SETTLE   = 2'b00;
    localparam [1:0]  ST_FIXED    = 2'b01;
    localparam [1:0]  ST_INT      = 2'b10;
    localparam [1:0]  ST_EXT      = 2'b11;
    localparam [1:0]  SETTLE_LAST = 2'h2;
    localparam [3:0]  PULSE_MIN   = `MMA_PULSE_MIN;
    localparam [3:0]  RUN_LAST    = `MMA_PULSE_MIN - 4'h1;
    localparam [31:0] WIN_LAST    = WIN_CYC - 1;
    localparam [31:0] GAP_LIM     = GAP_CYC;
    localparam [15:0] STRAP_DIV   = `MMA_STRAP_DIV;
    localparam [11:0] STRAP_THR   = `MMA_STRAP_THRESH_MV;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [11:0] strap_mv_s1_reg;
    reg  [11:0] strap_mv_s2_reg;
    reg  [31:0] strap_res_s1_reg;
    reg  [31:0] strap_res_s2_reg;
    reg  [1:0]  settle_cnt_reg;
    reg  [1:0]  settle_cnt_next;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         mod_prev_reg;
    reg  [31:0] gap_cnt_reg;
    reg  [31:0] gap_cnt_next;
    reg  [3:0]  run_cnt_reg;
    reg  [3:0]  run_cnt_next;
    reg  [31:0] win_cnt_reg;
    reg  [31:0] win_cnt_next;
    reg  [3:0]  win_pulses_reg;
    reg  [3:0]  win_pulses_next;
    reg         drive_next;
    wire        mod_in_sync;
    wire        rise;
    wire        gap_ok;
    wire        capture_now;
    wire        strap_above;
    wire [31:0] quotient;
    wire        train_step;
    wire        train_done;
    wire        window_end;
    wire [4:0]  win_total;
    wire        bypass_next;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    mma_sync2 u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d_in    (mcu_modulation_input),
        .q_out   (mod_in_sync)
    );

    // Strap level and resistor come from the analog side
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            strap_mv_s1_reg  <= 12'h000;
            strap_mv_s2_reg  <= 12'h000;
            strap_res_s1_reg <= 32'h0000_0000;
            strap_res_s2_reg <= 32'h0000_0000;
        end else begin
            strap_mv_s1_reg  <= strap_mv;
            strap_mv_s2_reg  <= strap_mv_s1_reg;
            strap_res_s1_reg <= strap_resistor;
            strap_res_s2_reg <= strap_res_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Strap settle and capture
    // ------------------------------------------------------------
    always @* begin
        settle_cnt_next = settle_cnt_reg;
        if (state_reg == ST_SETTLE && settle_cnt_reg != SETTLE_LAST) begin
            settle_cnt_next = settle_cnt_reg + 2'h1;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            settle_cnt_reg <= 2'h0;
        end else begin
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    assign capture_now = (state_reg == ST_SETTLE) && (settle_cnt_reg == SETTLE_LAST);
    assign strap_above = (strap_mv_s2_reg > STRAP_THR);
    // Resistor in milliohms gives target in millivolts
    assign quotient    = strap_res_s2_reg / STRAP_DIV;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            standalone_cfg <= 1'b0;
            target_mv      <= 16'h0000;
        end else if (capture_now) begin
            standalone_cfg <= strap_above;
            target_mv      <= quotient[15:0];
        end
    end

    // ------------------------------------------------------------
    // Pulse edges and gap timer
    // ------------------------------------------------------------
    assign rise   = mod_in_sync & ~mod_prev_reg;
    assign gap_ok = (gap_cnt_reg < GAP_LIM);

    always @* begin
        gap_cnt_next = gap_cnt_reg;
        if (rise) begin
            gap_cnt_next = 32'h0000_0000;
        end else if (gap_ok) begin
            gap_cnt_next = gap_cnt_reg + 32'h0000_0001;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mod_prev_reg <= 1'b0;
            gap_cnt_reg  <= 32'h0000_0000;
        end else begin
            mod_prev_reg <= mod_in_sync;
            gap_cnt_reg  <= gap_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Pulse train in stand-alone mode
    // ------------------------------------------------------------
    assign train_step = rise && (run_cnt_reg == 4'h0 || gap_ok);
    assign train_done = (state_reg == ST_INT) && train_step && (run_cnt_reg == RUN_LAST);

    always @* begin
        run_cnt_next = run_cnt_reg;
        if (state_reg != ST_INT) begin
            run_cnt_next = 4'h0;
        end else if (rise) begin
            if (train_done) begin
                run_cnt_next = 4'h0;
            end else if (train_step) begin
                run_cnt_next = run_cnt_reg + 4'h1;
            end else begin
                run_cnt_next = 4'h1;
            end
        end else if (!gap_ok) begin
            run_cnt_next = 4'h0;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_cnt_reg <= 4'h0;
        end else begin
            run_cnt_reg <= run_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Activity window in stand-alone bypass (ST_EXT only)
    // ------------------------------------------------------------
    assign window_end = (state_reg == ST_EXT) && (win_cnt_reg >= WIN_LAST);
    // Wide sum so a saturated count plus a rise never wraps
    assign win_total  = {1'b0, win_pulses_reg} + {4'h0, rise};

    always @* begin
        win_cnt_next    = win_cnt_reg;
        win_pulses_next = win_pulses_reg;
        if (state_reg != ST_EXT || window_end) begin
            win_cnt_next    = 32'h0000_0000;
            win_pulses_next = 4'h0;
        end else begin
            win_cnt_next = win_cnt_reg + 32'h0000_0001;
            if (rise && win_pulses_reg != PULSE_MIN) begin
                win_pulses_next = win_pulses_reg + 4'h1;
            end
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            win_cnt_reg    <= 32'h0000_0000;
            win_pulses_reg <= 4'h0;
        end else begin
            win_cnt_reg    <= win_cnt_next;
            win_pulses_reg <= win_pulses_next;
        end
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_SETTLE: begin
                if (capture_now) begin
                    state_next = strap_above ? ST_INT : ST_FIXED;
                end
            end
            ST_FIXED: begin
                state_next = ST_FIXED;
            end
            ST_INT: begin
                if (train_done) begin
                    state_next = ST_EXT;
                end
            end
            ST_EXT: begin
                if (window_end && win_total < {1'b0, PULSE_MIN}) begin
                    state_next = ST_INT;
                end
            end
            default: begin
                state_next = ST_SETTLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_SETTLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Switch drive
    // ------------------------------------------------------------
    always @* begin
        case (state_reg)
            ST_INT: begin
                drive_next = internal_mod_data;
            end
            ST_EXT, ST_FIXED: begin
                drive_next = mod_in_sync;
            end
            default: begin
                drive_next = 1'b0;
            end
        endcase
    end

    assign bypass_next = (state_reg == ST_EXT) || (state_reg == ST_FIXED);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            modulation_switch_a <= 1'b0;
            modulation_switch_b <= 1'b0;
            bypass_active       <= 1'b0;
        end else begin
            modulation_switch_a <= drive_next;
            modulation_switch_b <= drive_next;
            bypass_active       <= bypass_next;
        end
    end
endmodule // mma_modulator_mode_arbiter

// ==== mma_defs.vh ====
`ifndef MMA_DEFS_VH
`define MMA_DEFS_VH

// Strap threshold and scaling, millivolts
`define MMA_STRAP_THRESH_MV     12'h0FA
`define MMA_STRAP_DIV           16'h1388
`define MMA_CLK_MHZ             100
// Pulse gap limit in ms, window length in ms
`define MMA_GAP_MS              25
`define MMA_WIN_MS              250
`define MMA_CYC_PER_MS          100000
`define MMA_GAP_CYC             (`MMA_GAP_MS * `MMA_CYC_PER_MS)
`define MMA_WIN_CYC             (`MMA_WIN_MS * `MMA_CYC_PER_MS)
`define MMA_PULSE_MIN           4'h8
// Mode encodings
`define MMA_MODE_INTERNAL       1'b0
`define MMA_MODE_EXTERNAL       1'b1

`endif

// ==== mma_sync2.v ====
`timescale 1ns/1ps
module mma_sync2 (
    input  wire clk_sys,
    input  wire nrst,
    input  wire d_in,
    output wire q_out
);
    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule // mma_sync2

// ==== mma_chk.sv ====
`timescale 1ns/1ps
module mma_chk (
    input wire        clk_sys,
    input wire        nrst,
    input wire [11:0] strap_mv,
    input wire [31:0] strap_resistor,
    input wire        mcu_modulation_input,
    input wire        internal_mod_data,
    input wire        modulation_switch_a,
    input wire        modulation_switch_b,
    input wire        bypass_active,
    input wire        standalone_cfg,
    input wire [15:0] target_mv
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!nrst);
sequence ext_held; bypass_active && $past(bypass_active); endsequence
sequence int_held; !bypass_active && !$past(bypass_active) && $past(standalone_cfg); endsequence
gnd_hold_a: assert property ($fell(bypass_active) |-> standalone_cfg) else $error("left");
cfg_lo_a: assert property (strap_mv <= 12'h0FA |=> !standalone_cfg) else $error("lo");
cfg_hi_a: assert property ($rose(standalone_cfg) |->
    $past(strap_mv) > 12'h0FA) else $error("hi");
cfg_stay_a: assert property ($past(standalone_cfg) |-> standalone_cfg) else $error("cfg");
target_a: assert property ($rose(standalone_cfg) |-> ##[0:1]
    target_mv == 16'(strap_resistor / 5000)) else $error("target");
ext_follow_a: assert property (ext_held |->
    modulation_switch_a == $past(mcu_modulation_input, 3)) else $error("ext");
int_follow_a: assert property (int_held |->
    modulation_switch_a == $past(internal_mod_data)) else $error("int");
sw_pair_a: assert property (modulation_switch_a == modulation_switch_b) else $error("pair");
endmodule // mma_chk
bind mma_modulator_mode_arbiter mma_chk u_mma_chk (.*);

// ==== mma_mcu_model.sv ====
`timescale 1ns/1ps
module mma_mcu_model (
    input  wire       clk_sys,
    input  wire       go,
    input  wire [7:0] num,
    output logic      pin
);
// Pulses two cycles high, eight cycles rise to rise, low when idle
initial begin
    pin = 1'b0;
    forever @(posedge clk_sys iff go) repeat (num) begin
        @(negedge clk_sys) pin = 1'b1;
        repeat (2) @(negedge clk_sys);
        pin = 1'b0;
        repeat (5) @(negedge clk_sys);
    end
end
endmodule // mma_mcu_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
logic        clk_sys = 0, nrst = 0, go = 0, int_d = 0;
logic [11:0] strap_mv;
logic [31:0] strap_resistor;
logic [7:0]  num = 0;
wire         sw_a, sw_b, byp, cfg, pin;
wire  [15:0] tgt;
int          num_errors = 0, comparisons = 0;
// Strap level, resistor, stand-alone expected, target expected
logic [60:0] rows [4] = '{{12'h000, 32'h0, 1'b0, 16'h0}, {12'h0FA, 32'h0, 1'b0, 16'h0},
    {12'h0FB, 32'h004C4B40, 1'b1, 16'h03E8}, {12'hFFF, 32'h05F5E100, 1'b1, 16'h4E20}};
mma_modulator_mode_arbiter #(.GAP_CYC(20), .WIN_CYC(200)) u_mma_modulator_mode_arbiter (
    .clk_sys, .nrst, .strap_mv, .strap_resistor, .mcu_modulation_input(pin),
    .internal_mod_data(int_d), .modulation_switch_a(sw_a), .modulation_switch_b(sw_b),
    .bypass_active(byp), .standalone_cfg(cfg), .target_mv(tgt));
mma_mcu_model u_mma_mcu_model (.clk_sys, .go, .num, .pin);
initial forever #5 clk_sys = ~clk_sys;
task chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin num_errors++; $display("wrong value at %0t: %h vs %h", $time, got, exp); end
endtask
task burst(input logic [7:0] n);
    {num, go} = {n, 1'b1};
    @(negedge clk_sys) go = 0;
    repeat (8 * n + 2) @(negedge clk_sys);
endtask
task tally_and_finish;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
initial begin
    #100us num_errors++;
    tally_and_finish;
end
initial begin
    for (int i = 0; i < 4; i++) begin
        {nrst, int_d, strap_mv, strap_resistor} = {2'b00, rows[i][60:17]};
        repeat (6) @(negedge clk_sys);
        nrst = 1;
        repeat (250) @(negedge clk_sys);
        int_d = 1;
        repeat (9) @(negedge clk_sys);
        chk(cfg, rows[i][16]);
        chk(sw_a, rows[i][16]);
        chk(sw_b, rows[i][16]);
        chk(tgt, rows[i][15:0]);
        burst(7);
        chk(byp, !rows[i][16]);
        repeat (30) @(negedge clk_sys);
        burst(40);
        chk(byp, 1);
        chk(sw_a, 0);
        repeat (450) @(negedge clk_sys);
        chk(byp, !rows[i][16]);
        chk(sw_a, rows[i][16]);
        $display("row %0d done", i);
    end
    tally_and_finish;
end
endmodule // tb_top
